// [sofu_consts.svh]
/*
  Constants for the store order, fence and flush unit: opcode codes,
  memory types, line geometry and field positions.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef SOFU_CONSTS_SVH
`define SOFU_CONSTS_SVH

// ----------------------------------------
// Line geometry
// ----------------------------------------
`define SOFU_LINE_BYTES     64
`define SOFU_CHUNK_BYTES    16
`define SOFU_HALF_CHUNK_BYTES 8
`define SOFU_LINE_LSB       6
`define SOFU_CHUNK_LSB      4
`define SOFU_CHUNKS         4
`define SOFU_ADDR_W         32
`define SOFU_MSB_OF_BYTE    7

// ----------------------------------------
// Operation codes from the pipeline
// ----------------------------------------
`define SOFU_OP_W           4
`define SOFU_OP_NONE        4'h0
`define SOFU_OP_NT_INT64    4'h1
`define SOFU_OP_NT_INT128   4'h2
`define SOFU_OP_NT_PS       4'h3
`define SOFU_OP_MASK64      4'h4
`define SOFU_OP_MASK128     4'h5
`define SOFU_OP_SLOAD       4'h6
`define SOFU_OP_STORE_FENCE      4'h7
`define SOFU_OP_LOAD_FENCE      4'h8
`define SOFU_OP_MFENCE      4'h9
`define SOFU_OP_FLUSH       4'hA
`define SOFU_OP_PREFETCH    4'hB
`define SOFU_OP_STORE       4'hC
`define SOFU_OP_LOAD        4'hD

// ----------------------------------------
// Memory types
// ----------------------------------------
`define SOFU_MT_WB          2'h0
`define SOFU_MT_WC          2'h1
`define SOFU_MT_UC          2'h2

// ----------------------------------------
// Cache command codes toward the hierarchy
// ----------------------------------------
`define SOFU_CC_NONE        3'h0
`define SOFU_CC_WB_INV      3'h1
`define SOFU_CC_INV         3'h2
`define SOFU_CC_EVICT       3'h3
`define SOFU_CC_PREFETCH    3'h4
`define SOFU_CC_UPDATE      3'h5

`endif

// [sofu_mem_model.sv]
/*
  Far-side model of the unit: system bus and cache hierarchy.
  Assumes the unit holds each write and cache command valid until its acknowledge; a line read is a one-cycle pulse.
*/
`timescale 1ns/1ps
module sofu_mem_model (
  // Clock, reset and test control
  input  wire logic                      CLK_IN,
  input  wire logic                      RESET_IN,
  input  wire logic                      DIRTY_IN,
  // Requests from the unit
  input  wire sofu_pkg::sofu_bus_wr_t    BUS_WR_IN,
  input  wire logic                      BUS_RD_IN,
  input  wire logic [31:0]               BUS_RD_ADDR_IN,
  input  wire sofu_pkg::sofu_cache_cmd_t CACHE_CMD_IN,
  // Answers to the unit
  output logic                           WR_ACK_OUT,
  output logic                           RD_VALID_OUT,
  output logic [511:0]                   RD_DATA_OUT,
  output logic                           CACHE_ACK_OUT,
  output logic                           CACHE_DIRTY_OUT
);
  int          wr_wait;   // Slow bus: three cycles per write
  int          rd_wait;   // Read latency counter, zero when idle
  logic [31:0] rd_line;   // Line being fetched
  // Acknowledges are one-cycle pulses; data off the bus is junk when idle
  always @(posedge CLK_IN) begin
    WR_ACK_OUT <= 1'b0;
    CACHE_ACK_OUT <= 1'b0;
    RD_VALID_OUT <= 1'b0;
    CACHE_DIRTY_OUT <= ~DIRTY_IN;
    RD_DATA_OUT <= ~RD_DATA_OUT;
    wr_wait <= (BUS_WR_IN.valid && !WR_ACK_OUT) ? wr_wait + 1 : 0;
    if (BUS_WR_IN.valid && !WR_ACK_OUT && wr_wait == 2) WR_ACK_OUT <= 1'b1;
    if (CACHE_CMD_IN.valid && !CACHE_ACK_OUT) begin
      CACHE_ACK_OUT <= 1'b1;
      CACHE_DIRTY_OUT <= DIRTY_IN;
    end
    if (BUS_RD_IN) begin
      rd_wait <= 4;
      rd_line <= {BUS_RD_ADDR_IN[31:6], 6'h00};
    end else if (rd_wait > 0) rd_wait <= rd_wait - 1;
    if (rd_wait == 1) begin
      RD_VALID_OUT <= 1'b1;
      for (int i = 0; i < 16; i++) RD_DATA_OUT[i*32+:32] <= rd_line + i;
    end
    if (RESET_IN) rd_wait <= 0;
  end
endmodule // sofu_mem_model

// [sofu_pkg.sv]
/*
  Types of the store order, fence and flush unit.
  Assumes sofu_consts.svh is on the include path.
*/
`include "sofu_consts.svh"

package sofu_pkg;

  // Request from the load/store pipeline
  typedef struct packed {
    logic                       valid;
    logic [`SOFU_OP_W-1:0]      op;
    logic [`SOFU_ADDR_W-1:0]    addr;
    logic [127:0]               data;
    logic [127:0]               mask;
    logic [1:0]                 mtype;
    logic                       perm_ok;
    logic [1:0]                 hint;
  } sofu_req_t;

  // Write toward the system bus
  typedef struct packed {
    logic                       valid;
    logic [`SOFU_ADDR_W-1:0]    addr;
    logic [511:0]               data;
    logic [63:0]                be;
  } sofu_bus_wr_t;

  // Command toward the cache hierarchy
  typedef struct packed {
    logic                       valid;
    logic [2:0]                 cmd;
    logic [`SOFU_ADDR_W-1:0]    addr;
    logic                       broadcast;
    logic                       no_alloc;
  } sofu_cache_cmd_t;

  typedef enum logic [2:0] {
    SOFU_IDLE, SOFU_DRAIN, SOFU_FENCE_WAIT, SOFU_FLUSH_WB, SOFU_FLUSH_INV, SOFU_SLOAD_FETCH
  } sofu_state_t;

  // Whole module state
  typedef struct packed {
    sofu_state_t                st;
    logic                       wcb_valid;
    logic [`SOFU_ADDR_W-1:0]    wcb_line;
    logic [511:0]               wcb_data;
    logic [63:0]                wcb_be;
    logic                       hb_valid;
    logic [`SOFU_ADDR_W-1:0]    hb_line;
    logic [511:0]               hb_data;
    logic [3:0]                 hb_read;
    logic [1:0]                 fence_kind;
    logic [`SOFU_ADDR_W-1:0]    fl_addr;
    logic                       done;
    logic                       fault;
    logic [127:0]               rdata;
    sofu_bus_wr_t               bw;
    sofu_cache_cmd_t            cc;
    logic                       bus_rd;
    logic [`SOFU_ADDR_W-1:0]    bus_rd_addr;
  } sofu_st_t;

endpackage

// [sofu_unit.sv]
/*
  Store order, fence and flush unit: streaming stores with a one-line
  write-combining buffer, streaming load holding buffer, store/load/full
  fences, line flush and prefetch hints.
  Assumes the pipeline holds a request until done or fault pulses, and that
  the cache and bus answer with one-cycle acknowledge/valid pulses.
*/
// Overview of operation
// - Integer streaming stores weakly ordered, never allocate
// - Packed-single store unaligned to 16 bytes faults
// - Masked store writes bytes whose mask top bit set
// - Masked stores may reorder, never allocate
// - Streaming load 16 bytes, nontemporal only for WC
// - WC source fetched whole line into holding buffer
// - Later loads served from held unread chunks
// - Store fence orders older before younger stores
// - Load fence orders older before younger loads
// - Full fence orders all older accesses first
// - Load and store fences mutually unordered
// - Flush invalidates line in all data/instruction caches
// - Flush invalidation broadcast to coherence domain
// - Dirty flushed line written back before invalidate
// - Flush covers one 64-byte line, type ignored
// - Flush allowed everywhere, checked like byte load
// - Flushes unordered except by explicit fences
// - Non-coherent I/O traffic is never snooped
// - WC region data never installed in caches
// - Cached non-WC hit may update in place
// - Evicting hit writes cached copy out itself
// - Four prefetch variants are hints only
// - Same-line streaming stores merged before issue
// - Faulting prefetch dropped silently
`timescale 1ns/1ps
`include "sofu_consts.svh"

module sofu_unit #(
  parameter bit EVICT_ON_HIT = 1'b0          // Select evict policy for streaming-store hits
) (
  // Clock and reset
  input  wire logic                      CLK_IN,
  input  wire logic                      RESET_IN,
  // Pipeline request and answer
  input  wire sofu_pkg::sofu_req_t       REQ_IN,
  output logic                           DONE_OUT,
  output logic                           FAULT_OUT,
  output logic [127:0]                   RDATA_OUT,
  // Ordering and hit status from the rest of the memory pipeline
  input  wire logic                      OLDER_LOADS_PEND_IN,
  input  wire logic                      OLDER_STORES_PEND_IN,
  input  wire logic                      HIT_IN,
  // Bus write side
  output sofu_pkg::sofu_bus_wr_t         BUS_WR_OUT,
  input  wire logic                      BUS_WR_ACK_IN,
  // Bus line read side
  output logic                           BUS_RD_OUT,
  output logic [`SOFU_ADDR_W-1:0]        BUS_RD_ADDR_OUT,
  input  wire logic                      BUS_RD_VALID_IN,
  input  wire logic [511:0]              BUS_RD_DATA_IN,
  // Cache hierarchy command side
  output sofu_pkg::sofu_cache_cmd_t      CACHE_CMD_OUT,
  input  wire logic                      CACHE_ACK_IN,
  input  wire logic                      CACHE_DIRTY_IN
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sofu_pkg::sofu_st_t r;                      // Registered state
  sofu_pkg::sofu_st_t next_r;                 // Next state

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic                     is_nt;            // Any streaming store
  logic                     is_mask;          // Byte-masked store
  logic [`SOFU_ADDR_W-1:0]  line_of_req;      // Line-aligned address
  logic [1:0]               chunk_of_req;     // 16-byte chunk index
  logic [63:0]              be_new;           // Byte enables in the line
  logic [511:0]             data_new;         // Data placed in the line
  logic [63:0]              lane_be;          // Lane enables before shift
  logic                     misaligned;       // Low address bits set

  assign is_nt = REQ_IN.op inside {`SOFU_OP_NT_INT64, `SOFU_OP_NT_INT128, `SOFU_OP_NT_PS,
                                   `SOFU_OP_MASK64, `SOFU_OP_MASK128};
  assign is_mask = REQ_IN.op inside {`SOFU_OP_MASK64, `SOFU_OP_MASK128};
  assign line_of_req = {REQ_IN.addr[`SOFU_ADDR_W-1:`SOFU_LINE_LSB], {`SOFU_LINE_LSB{1'b0}}};
  assign chunk_of_req = REQ_IN.addr[`SOFU_LINE_LSB-1:`SOFU_CHUNK_LSB];
  assign misaligned = |REQ_IN.addr[`SOFU_CHUNK_LSB-1:0];

  // Per-byte lane enable; masked stores look only at each mask byte's top bit
  genvar gi;
  generate
    for (gi = 0; gi < `SOFU_CHUNK_BYTES; gi++) begin : g_lane
      always_comb begin
        // 64-bit forms own only the low half of the chunk, masked or not
        if ((REQ_IN.op == `SOFU_OP_NT_INT64 || REQ_IN.op == `SOFU_OP_MASK64) &&
            gi >= `SOFU_HALF_CHUNK_BYTES) begin
          lane_be[gi] = 1'b0;
        end else if (is_mask) begin
          lane_be[gi] = REQ_IN.mask[gi*8 + `SOFU_MSB_OF_BYTE];
        end else begin
          lane_be[gi] = 1'b1;
        end
      end
    end
    for (gi = `SOFU_CHUNK_BYTES; gi < `SOFU_LINE_BYTES; gi++) begin : g_hi
      assign lane_be[gi] = 1'b0;
    end
  endgenerate

  // Place the 16-byte store at its offset; 64-bit stores keep their 8-byte-aligned offset
  always_comb begin
    logic [5:0] ofs;
    ofs = {REQ_IN.addr[`SOFU_LINE_LSB-1:3], 3'h0};
    if (REQ_IN.op == `SOFU_OP_NT_INT64 || REQ_IN.op == `SOFU_OP_MASK64) begin
      be_new   = lane_be << ofs;
      data_new = {384'h0, REQ_IN.data} << {ofs, 3'h0};
    end else begin
      be_new   = lane_be << {chunk_of_req, 4'h0};
      data_new = {384'h0, REQ_IN.data} << {chunk_of_req, 7'h0};
    end
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // One operation is handled at a time; the pipeline holds its request
  // until done or fault, which keeps the sequencer simple at the cost of
  // one outstanding operation.
  always_comb begin
    next_r           = r;
    next_r.done      = 1'b0;
    next_r.fault     = 1'b0;
    next_r.bw.valid  = r.bw.valid & ~BUS_WR_ACK_IN;
    next_r.cc.valid  = r.cc.valid & ~CACHE_ACK_IN;
    next_r.bus_rd    = 1'b0;
    // A store or flush on the held line kills the holding buffer
    if (REQ_IN.valid && r.hb_valid && line_of_req == r.hb_line &&
        (is_nt || REQ_IN.op == `SOFU_OP_STORE || REQ_IN.op == `SOFU_OP_FLUSH)) begin
      next_r.hb_valid = 1'b0;
    end
    unique case (r.st)
      sofu_pkg::SOFU_IDLE: begin
        if (REQ_IN.valid && !r.done && !r.fault) begin
          if (is_nt) begin
            if (REQ_IN.op == `SOFU_OP_NT_PS && misaligned) begin
              next_r.fault = 1'b1;
            end else if (HIT_IN && REQ_IN.mtype != `SOFU_MT_WC && !EVICT_ON_HIT) begin
              // In-place update; later fences do not push it out
              next_r.cc = '{1'b1, `SOFU_CC_UPDATE, REQ_IN.addr, 1'b0, 1'b1};
              next_r.done = 1'b1;
            end else if (r.wcb_valid && r.wcb_line != line_of_req) begin
              next_r.st = sofu_pkg::SOFU_DRAIN;                  // Other line: drain first
            end else begin
              // Merge into the buffer; bytes written later overwrite earlier ones
              next_r.wcb_valid = 1'b1;
              next_r.wcb_line  = line_of_req;
              next_r.wcb_be    = (r.wcb_valid ? r.wcb_be : 64'h0) | be_new;
              for (int b = 0; b < `SOFU_LINE_BYTES; b++) begin
                if (be_new[b]) begin
                  next_r.wcb_data[b*8 +: 8] = data_new[b*8 +: 8];
                end
              end
              if (HIT_IN && EVICT_ON_HIT) begin
                // Cached copy leaves with the streaming store
                next_r.cc = '{1'b1, `SOFU_CC_EVICT, line_of_req, 1'b0, 1'b1};
              end
              next_r.done = 1'b1;
            end
          end else if (REQ_IN.op inside {`SOFU_OP_STORE_FENCE, `SOFU_OP_MFENCE, `SOFU_OP_LOAD_FENCE}) begin
            next_r.fence_kind = REQ_IN.op == `SOFU_OP_STORE_FENCE ? 2'h1 :
                                REQ_IN.op == `SOFU_OP_LOAD_FENCE ? 2'h2 : 2'h3;
            next_r.st = (REQ_IN.op != `SOFU_OP_LOAD_FENCE && r.wcb_valid) ?
                        sofu_pkg::SOFU_DRAIN : sofu_pkg::SOFU_FENCE_WAIT;
          end else if (REQ_IN.op == `SOFU_OP_FLUSH) begin
            if (!REQ_IN.perm_ok) begin
              next_r.fault = 1'b1;
            end else begin
              // No wait on other traffic; memory type not looked at
              next_r.fl_addr = line_of_req;
              next_r.cc = '{1'b1, `SOFU_CC_WB_INV, line_of_req, 1'b1, 1'b0};
              next_r.st = sofu_pkg::SOFU_FLUSH_WB;
            end
          end else if (REQ_IN.op == `SOFU_OP_SLOAD) begin
            if (REQ_IN.mtype != `SOFU_MT_WC) begin
              next_r.st = sofu_pkg::SOFU_FENCE_WAIT;             // ordinary load path
              next_r.fence_kind = 2'h0;
            end else if (r.hb_valid && r.hb_line == line_of_req && !r.hb_read[chunk_of_req] &&
                         next_r.hb_valid) begin
              next_r.rdata = r.hb_data[{chunk_of_req, 7'h0} +: 128];
              next_r.hb_read[chunk_of_req] = 1'b1;
              next_r.done = 1'b1;
            end else begin
              next_r.bus_rd = 1'b1;
              next_r.bus_rd_addr = line_of_req;
              next_r.hb_line = line_of_req;
              next_r.hb_valid = 1'b0;                            // Stale line must not serve meanwhile
              next_r.st = sofu_pkg::SOFU_SLOAD_FETCH;
            end
          end else if (REQ_IN.op == `SOFU_OP_PREFETCH) begin
            // Hint only; a faulting or WC/UC target is dropped silently
            if (REQ_IN.perm_ok && REQ_IN.mtype == `SOFU_MT_WB) begin
              next_r.cc = '{1'b1, `SOFU_CC_PREFETCH, line_of_req, 1'b0, 1'b0};
            end
            next_r.done = 1'b1;
          end else begin
            next_r.done = 1'b1;
          end
        end
      end
      sofu_pkg::SOFU_DRAIN: begin
        // Whole line goes out as one combined write
        if (!r.bw.valid) begin
          next_r.bw = '{1'b1, r.wcb_line, r.wcb_data, r.wcb_be};
          next_r.wcb_valid = 1'b0;
          next_r.wcb_be = 64'h0;
        end else if (BUS_WR_ACK_IN) begin
          next_r.st = (r.fence_kind != 2'h0 && REQ_IN.op != `SOFU_OP_NONE && !is_nt) ?
                      sofu_pkg::SOFU_FENCE_WAIT : sofu_pkg::SOFU_IDLE;
        end
      end
      sofu_pkg::SOFU_FENCE_WAIT: begin
        // Store fence ignores loads, load fence ignores stores
        unique case (r.fence_kind)
          2'h1: if (!OLDER_STORES_PEND_IN) next_r.done = 1'b1;
          2'h2: if (!OLDER_LOADS_PEND_IN) next_r.done = 1'b1;
          2'h3: if (!OLDER_STORES_PEND_IN && !OLDER_LOADS_PEND_IN) next_r.done = 1'b1;
          default: next_r.done = 1'b1;
        endcase
        if (next_r.done) begin
          next_r.st = sofu_pkg::SOFU_IDLE;
          next_r.fence_kind = 2'h0;
        end
      end
      sofu_pkg::SOFU_FLUSH_WB: begin
        // Dirty copy written back first, then the invalidate is broadcast
        if (CACHE_ACK_IN) begin
          if (CACHE_DIRTY_IN) begin
            next_r.bw = '{1'b1, r.fl_addr, 512'h0, 64'h0};       // data from cache
          end
          next_r.st = sofu_pkg::SOFU_FLUSH_INV;
        end
      end
      sofu_pkg::SOFU_FLUSH_INV: begin
        if (!r.bw.valid && !r.cc.valid) begin
          next_r.cc = '{1'b1, `SOFU_CC_INV, r.fl_addr, 1'b1, 1'b0};
        end else if (r.cc.valid && CACHE_ACK_IN) begin
          next_r.done = 1'b1;
          next_r.st = sofu_pkg::SOFU_IDLE;
        end
      end
      sofu_pkg::SOFU_SLOAD_FETCH: begin
        // Line held privately; never installed in a cache
        if (BUS_RD_VALID_IN) begin
          next_r.hb_valid = 1'b1;
          next_r.hb_data  = BUS_RD_DATA_IN;
          next_r.hb_read  = 4'h0;
          next_r.hb_read[chunk_of_req] = 1'b1;
          next_r.rdata = BUS_RD_DATA_IN[{chunk_of_req, 7'h0} +: 128];
          next_r.done = 1'b1;
          next_r.st = sofu_pkg::SOFU_IDLE;
        end
      end
      default: next_r.st = sofu_pkg::SOFU_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Non-coherent I/O traffic never reaches this unit, so no snoop port exists
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign DONE_OUT        = r.done;
  assign FAULT_OUT       = r.fault;
  assign RDATA_OUT       = r.rdata;
  assign BUS_WR_OUT      = r.bw;
  assign BUS_RD_OUT      = r.bus_rd;
  assign BUS_RD_ADDR_OUT = r.bus_rd_addr;
  assign CACHE_CMD_OUT   = r.cc;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_flush_start;
    r.st == sofu_pkg::SOFU_IDLE && REQ_IN.valid && REQ_IN.op == `SOFU_OP_FLUSH && REQ_IN.perm_ok
      && !r.done && !r.fault;
  endsequence

  // Streaming load that misses the held line
  sequence s_sload_miss;
    r.st == sofu_pkg::SOFU_IDLE && REQ_IN.valid && REQ_IN.op == `SOFU_OP_SLOAD && REQ_IN.mtype == `SOFU_MT_WC
      && !r.done && !r.fault && !(r.hb_valid && r.hb_line == line_of_req && !r.hb_read[chunk_of_req]);
  endsequence

  a_ps_misalign: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    r.st == sofu_pkg::SOFU_IDLE && REQ_IN.valid && REQ_IN.op == `SOFU_OP_NT_PS && misaligned
      && !r.done && !r.fault |=> FAULT_OUT && !r.bw.valid) else $error("misaligned store not faulted");
  a_flush_bcast: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    s_flush_start |=> CACHE_CMD_OUT.valid && CACHE_CMD_OUT.broadcast) else $error("flush not broadcast");
  a_flush_perm: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    r.st == sofu_pkg::SOFU_IDLE && REQ_IN.valid && REQ_IN.op == `SOFU_OP_FLUSH && !REQ_IN.perm_ok
      && !r.done && !r.fault |=> FAULT_OUT) else $error("flush permission fault missing");
  a_store_fence_wait: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    r.st == sofu_pkg::SOFU_FENCE_WAIT && r.fence_kind == 2'h1 && OLDER_STORES_PEND_IN |=> !DONE_OUT)
    else $error("store fence retired early");
  a_load_fence_wait: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    r.st == sofu_pkg::SOFU_FENCE_WAIT && r.fence_kind == 2'h2 && !OLDER_LOADS_PEND_IN |=> DONE_OUT)
    else $error("load fence held by stores");
  a_mfence_wait: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    r.st == sofu_pkg::SOFU_FENCE_WAIT && r.fence_kind == 2'h3 && OLDER_LOADS_PEND_IN |=> !DONE_OUT)
    else $error("full fence retired early");
  a_fence_drain: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    r.st == sofu_pkg::SOFU_FENCE_WAIT && r.fence_kind[0] |-> !r.wcb_valid) else $error("fence before drain");
  a_wc_noinstall: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    r.st == sofu_pkg::SOFU_SLOAD_FETCH |-> !(CACHE_CMD_OUT.valid && CACHE_CMD_OUT.cmd == `SOFU_CC_PREFETCH))
    else $error("WC line installed");
  a_hb_kill: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    REQ_IN.valid && REQ_IN.op == `SOFU_OP_STORE && r.hb_valid && line_of_req == r.hb_line |=> !r.hb_valid)
    else $error("holding buffer not dropped");
  a_pf_silent: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    r.st == sofu_pkg::SOFU_IDLE && REQ_IN.valid && REQ_IN.op == `SOFU_OP_PREFETCH && !r.done
      && !r.fault |=> DONE_OUT && !FAULT_OUT) else $error("prefetch signalled fault");
  a_sload_fetch: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    s_sload_miss |=> BUS_RD_OUT && r.st == sofu_pkg::SOFU_SLOAD_FETCH && !r.hb_valid)
    else $error("line fetch not started");
  a_flush_order: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    r.st == sofu_pkg::SOFU_FLUSH_INV && r.bw.valid |=> !(CACHE_CMD_OUT.valid && CACHE_CMD_OUT.cmd == `SOFU_CC_INV))
    else $error("invalidate before write-back");
  a_mask64_lanes: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    REQ_IN.valid && REQ_IN.op == `SOFU_OP_MASK64 |-> lane_be[`SOFU_CHUNK_BYTES-1:`SOFU_HALF_CHUNK_BYTES] == '0)
    else $error("short masked store spills");

endmodule // sofu_unit

// [sofu_unit_tb_top.sv]
/*
  Self-checking testbench of the store order, fence and flush unit.
  Assumes sofu_pkg, sofu_unit and sofu_mem_model are compiled before it.
*/
`timescale 1ns/1ps
`include "sofu_consts.svh"
module sofu_unit_tb_top;
  logic clk = 1'b0, rst = 1'b1, lpend = 1'b0, spend = 1'b0, dirty = 1'b0, hit = 1'b0;
  logic done, fault, brd, wack, rdv, cack, cdirty;
  logic [127:0] rdata;
  logic [31:0] brd_addr;
  logic [511:0] rd_data;
  logic [2:0] cmd_log [8];
  sofu_pkg::sofu_req_t req = '0;
  localparam logic [127:0] data_pat = 128'hA5A5_0000_1234_5678_9ABC_DEF0_0F0F_F0F0;
  logic [511:0] last_data;
  sofu_pkg::sofu_bus_wr_t bw;
  sofu_pkg::sofu_cache_cmd_t cc;
  int err_total = 0, checks_done = 0, cycles = 0, wr_n = 0, rd_n = 0, cc_n = 0, wr_at_inv = 0;
  logic [63:0] last_be;
  logic bc_all = 1'b1;
  logic dn, fl;
  int cyc, b, c;
  always #25 clk = ~clk;
  sofu_unit u_sofu_unit (.CLK_IN(clk), .RESET_IN(rst), .REQ_IN(req), .DONE_OUT(done), .FAULT_OUT(fault),
    .RDATA_OUT(rdata), .OLDER_LOADS_PEND_IN(lpend), .OLDER_STORES_PEND_IN(spend), .HIT_IN(hit),
    .BUS_WR_OUT(bw), .BUS_WR_ACK_IN(wack), .BUS_RD_OUT(brd), .BUS_RD_ADDR_OUT(brd_addr),
    .BUS_RD_VALID_IN(rdv), .BUS_RD_DATA_IN(rd_data), .CACHE_CMD_OUT(cc), .CACHE_ACK_IN(cack),
    .CACHE_DIRTY_IN(cdirty));
  sofu_mem_model u_sofu_mem_model (.CLK_IN(clk), .RESET_IN(rst), .DIRTY_IN(dirty), .BUS_WR_IN(bw),
    .BUS_RD_IN(brd), .BUS_RD_ADDR_IN(brd_addr), .CACHE_CMD_IN(cc), .WR_ACK_OUT(wack),
    .RD_VALID_OUT(rdv), .RD_DATA_OUT(rd_data), .CACHE_ACK_OUT(cack), .CACHE_DIRTY_OUT(cdirty));
  // Bus and cache traffic log, plus the hang guard
  always @(posedge clk) begin
    if (bw.valid && wack) begin
      wr_n++;
      last_be = bw.be;
      last_data = bw.data;
    end
    if (brd) rd_n++;
    if (cc.valid && cack) begin
      cmd_log[cc_n%8] = cc.cmd;
      bc_all = bc_all & cc.broadcast;
      if (cc.cmd === `SOFU_CC_INV) wr_at_inv = wr_n;
      cc_n++;
    end
    cycles++;
    if (cycles > 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic cmp_val(input logic [511:0] got, input logic [511:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Request held until the one-cycle answer, released on the next falling edge
  task automatic do_req(input logic [3:0] op, input logic [31:0] a, input logic [127:0] m, input logic [1:0] mt,
    input logic p);
    @(negedge clk);
    req = '{1'b1, op, a, data_pat, m, mt, p, 2'h0};
    dn = 1'b0;
    fl = 1'b0;
    for (cyc = 0; cyc < 400 && !dn && !fl; cyc++) begin
      @(posedge clk);
      #1;
      dn = (done === 1'b1);
      fl = (fault === 1'b1);
    end
    if (!dn && !fl) begin
      err_total++;
      end_of_test();
    end
    @(negedge clk);
    req.valid = 1'b0;
  endtask
  // Fence held up by pending older accesses that clear after twenty cycles
  task automatic t_fence(input logic [3:0] op, input logic l, input logic s, input logic slow);
    @(negedge clk);
    lpend = l;
    spend = s;
    fork
      begin
        repeat (20) @(negedge clk);
        lpend = 1'b0;
        spend = 1'b0;
      end
      do_req(op, 32'h0000_0000, '0, `SOFU_MT_WB, 1'b1);
    join
    cmp_val(dn, 1'b1);
    cmp_val(cyc >= 15, slow);
  endtask
  task automatic t_stores();
    b = wr_n;
    do_req(`SOFU_OP_NT_INT128, 32'h0000_0100, '0, `SOFU_MT_WB, 1'b1);
    do_req(`SOFU_OP_NT_INT128, 32'h0000_0110, '0, `SOFU_MT_WB, 1'b1);
    cmp_val(wr_n, b);
    do_req(`SOFU_OP_STORE_FENCE, 32'h0000_0000, '0, `SOFU_MT_WB, 1'b1);
    cmp_val(wr_n, b + 1);
    cmp_val(last_be, 64'h0000_0000_FFFF_FFFF);
    cmp_val(last_data[255:0], {data_pat, data_pat});
    do_req(`SOFU_OP_MASK128, 32'h0000_0200, {8{16'h0080}}, `SOFU_MT_WB, 1'b1);
    do_req(`SOFU_OP_NT_INT64, 32'h0000_0500, '0, `SOFU_MT_WB, 1'b1);
    cmp_val(last_be, 64'h0000_0000_0000_5555);
    do_req(`SOFU_OP_MASK64, 32'h0000_0508, {8{16'h0080}}, `SOFU_MT_WB, 1'b1);
    do_req(`SOFU_OP_STORE_FENCE, 32'h0000_0000, '0, `SOFU_MT_WB, 1'b1);
    cmp_val(last_be, 64'h0000_0000_0000_55FF);
    do_req(`SOFU_OP_NT_PS, 32'h0000_0108, '0, `SOFU_MT_WB, 1'b1);
    cmp_val(fl, 1'b1);
  endtask
  task automatic t_flush();
    dirty = 1'b1;
    b = cc_n;
    c = wr_n;
    do_req(`SOFU_OP_FLUSH, 32'h0000_0305, '0, `SOFU_MT_WB, 1'b1);
    cmp_val({cmd_log[b%8], cmd_log[(b+1)%8]}, {`SOFU_CC_WB_INV, `SOFU_CC_INV});
    cmp_val(wr_at_inv, c + 1);
    cmp_val(bc_all, 1'b1);
    do_req(`SOFU_OP_FLUSH, 32'h0000_0340, '0, `SOFU_MT_WC, 1'b1);
    cmp_val(cc_n, b + 4);
    do_req(`SOFU_OP_FLUSH, 32'h0000_0380, '0, `SOFU_MT_WB, 1'b0);
    cmp_val(fl, 1'b1);
    do_req(`SOFU_OP_PREFETCH, 32'h0000_0380, '0, `SOFU_MT_WB, 1'b0);
    cmp_val(fl, 1'b0);
    do_req(`SOFU_OP_PREFETCH, 32'h0000_0380, '0, `SOFU_MT_WB, 1'b1);
    repeat (3) @(negedge clk);
    cmp_val({fl, cmd_log[(b+4)%8]}, {1'b0, `SOFU_CC_PREFETCH});
  endtask
  task automatic t_hit();
    b = wr_n;
    c = cc_n;
    hit = 1'b1;
    do_req(`SOFU_OP_NT_INT128, 32'h0000_0700, '0, `SOFU_MT_WB, 1'b1);
    hit = 1'b0;
    do_req(`SOFU_OP_STORE_FENCE, 32'h0000_0000, '0, `SOFU_MT_WB, 1'b1);
    cmp_val({cc_n, wr_n, cmd_log[c%8]}, {c + 1, b, `SOFU_CC_UPDATE});
  endtask
  task automatic t_sload();
    b = rd_n;
    do_req(`SOFU_OP_SLOAD, 32'h0000_0400, '0, `SOFU_MT_WC, 1'b1);
    cmp_val(rd_n, b + 1);
    cmp_val(rdata, {32'h0000_0403, 32'h0000_0402, 32'h0000_0401, 32'h0000_0400});
    c = cc_n;
    do_req(`SOFU_OP_SLOAD, 32'h0000_0410, '0, `SOFU_MT_WC, 1'b1);
    cmp_val(rdata, {32'h0000_0407, 32'h0000_0406, 32'h0000_0405, 32'h0000_0404});
    cmp_val({cc_n, rd_n}, {c, b + 1});
    do_req(`SOFU_OP_STORE, 32'h0000_0420, '0, `SOFU_MT_WC, 1'b1);
    do_req(`SOFU_OP_SLOAD, 32'h0000_0420, '0, `SOFU_MT_WC, 1'b1);
    cmp_val(rd_n, b + 2);
    cmp_val(rdata, {32'h0000_040B, 32'h0000_040A, 32'h0000_0409, 32'h0000_0408});
    do_req(`SOFU_OP_SLOAD, 32'h0000_0800, '0, `SOFU_MT_WB, 1'b1);
    cmp_val(rd_n, b + 2);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_stores();
    t_fence(`SOFU_OP_STORE_FENCE, 1'b0, 1'b1, 1'b1);
    t_fence(`SOFU_OP_STORE_FENCE, 1'b1, 1'b0, 1'b0);
    t_fence(`SOFU_OP_LOAD_FENCE, 1'b0, 1'b1, 1'b0);
    t_fence(`SOFU_OP_LOAD_FENCE, 1'b1, 1'b0, 1'b1);
    t_fence(`SOFU_OP_MFENCE, 1'b1, 1'b0, 1'b1);
    t_flush();
    t_hit();
    t_sload();
    end_of_test();
  end
endmodule // sofu_unit_tb_top
